/* design/opl_link.sv */
// What this block does
// - every byte or frame starts with a half-high start bit setting strobe.
// - a one is 75% high, a zero is 25% high.
// - line stays high 32 us between packets whatever the baud.
// - incoming line sampled at 512 kHz, works from 6 to 48 kHz baud.
// - parity checked on both bytes, frames with edge time-out rejected.
// - successfully executed command answered with byte A5.
// - outgoing bytes are start, eight data bits, parity.
// - bridge-only output sends high then low byte, top two bits zero.
// - line held high 32 us between bytes of a packet.
// - bridge plus temperature output sends three bytes incl. temperature.
// - memory read request returns fourteen bytes in one packet.
// - transmit 32 kHz for fast rates, 8 kHz for slow rates.
// - idle gap between packets 1.0, 4.85, 22.5 or 118 ms.
// - temperature measurement every 128, 64, 16 or 8 bridge measurements.
// - rates other than 1 ms power down, then power on, settle, convert, calculate before output.
// - pull-up on only in digital output and power-up window.
// - command in high byte, data in low byte.
// - in power-up window only the enter command is accepted.
`timescale 1ns/1ps
module opl_link
  import opl_pkg::*;
#(
  parameter int SLOW_BIT_CYC = CLOCK_HZ / SLOW_BAUD_HZ,
  parameter int WINDOW_CYC   = WINDOW_US * 1000 / CLK_PERIOD_NS,
  parameter int IDLE_R0_CYC  = IDLE_R0_US * 1000 / CLK_PERIOD_NS,
  parameter int IDLE_R1_CYC  = IDLE_R1_US * 1000 / CLK_PERIOD_NS,
  parameter int IDLE_R2_CYC  = IDLE_R2_US * 1000 / CLK_PERIOD_NS,
  parameter int IDLE_R3_CYC  = IDLE_R3_US * 1000 / CLK_PERIOD_NS,
  parameter int PWR_ON_CYC   = PWR_ON_US * 1000 / CLK_PERIOD_NS,
  parameter int CONVERT_CYC  = CONVERT_US * 1000 / CLK_PERIOD_NS,
  parameter int CALC_CYC     = CALC_US * 1000 / CLK_PERIOD_NS
)(
  input  wire logic                          CLOCK,
  input  wire logic                          RST,
  input  wire logic                          LINE_IN,
  output logic                               LINE_OUT,
  output logic                               LINE_OE,
  output logic                               PULLUP_EN,
  input  wire logic                          DIGITAL_MODE,
  input  wire logic                          WITH_TEMP,
  input  wire logic [1:0]                    UPDATE_RATE,
  input  wire opl_meas_type                  MEAS,
  input  wire logic [NVM_BYTES-1:0][7:0]     NVM_IMAGE,
  output logic                               CMD_VALID,
  output opl_cmd_type                        CMD_FRAME,
  input  wire logic                          CMD_DONE,
  output opl_mode_type                       MODE,
  output logic                               TEMP_MEAS,
  output logic                               POWER_DOWN,
  output opl_phase_type                      PHASE
);

  function automatic logic even_ok(input logic [8:0] v);
    even_ok = ~^v;
  endfunction

  function automatic opl_cnt_type idle_cyc(input logic [1:0] rate);
    if (rate == RATE_1MS)
      idle_cyc = CNT_W'(IDLE_R0_CYC);
    else if (rate == RATE_5MS)
      idle_cyc = CNT_W'(IDLE_R1_CYC);
    else if (rate == RATE_25MS)
      idle_cyc = CNT_W'(IDLE_R2_CYC);
    else
      idle_cyc = CNT_W'(IDLE_R3_CYC);
  endfunction

  function automatic logic [7:0] temp_last(input logic [1:0] rate);
    if (rate == RATE_1MS)
      temp_last = 8'(TEMP_EVERY_R0 - 1);
    else if (rate == RATE_5MS)
      temp_last = 8'(TEMP_EVERY_R1 - 1);
    else if (rate == RATE_25MS)
      temp_last = 8'(TEMP_EVERY_R2 - 1);
    else
      temp_last = 8'(TEMP_EVERY_R3 - 1);
  endfunction

  opl_mode_type          mode;
  opl_tx_type            tx_state;
  opl_rx_type            rx_state;
  opl_src_type           tx_src;
  opl_meas_type          tx_meas;
  opl_cnt_type           tx_cnt;
  opl_cnt_type           tx_period;
  opl_cnt_type           low_len;
  opl_cnt_type           win_cnt;
  opl_cnt_type           idle_cnt;
  opl_cnt_type           idle_end;
  opl_cnt_type           remain;
  opl_phase_type         next_phase;
  logic [1:0]            line_sync;
  logic                  line_now;
  logic [6:0]            tick_cnt;
  logic                  tick;
  logic                  rx_prev;
  logic [TICK_W-1:0]     rx_cnt;
  logic [TICK_W-1:0]     rx_strobe;
  logic [4:0]            rx_bits;
  logic [17:0]           rx_shift;
  logic                  rx_done;
  logic                  rx_ok;
  logic                  rx_timeout;
  opl_cmd_type           rx_frame;
  logic [3:0]            tx_bit;
  logic [3:0]            tx_idx;
  logic [3:0]            tx_len;
  logic [7:0]            tx_byte;
  logic                  tx_bitv;
  logic                  tx_low;
  logic                  tx_done;
  logic                  go_ack;
  logic                  go_nvm;
  logic                  go_nom;
  logic                  ack_req;
  logic                  nvm_req;
  logic                  ack_set;
  logic                  nvm_set;
  logic                  seq_wait;
  logic                  cycle_end;
  logic [7:0]            meas_cnt;
  opl_cnt_type           quiet_cnt;
  logic                  quiet;

  ////////////////////////////////////////////////////////////////////////////
  // line synchroniser and sample tick
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      line_sync <= 2'b11;
    else
      line_sync <= {line_sync[0], LINE_IN};
  end
  assign line_now = line_sync[1];

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      tick_cnt <= 7'h00;
    else if (tick)
      tick_cnt <= 7'h00;
    else
      tick_cnt <= 7'(tick_cnt + 7'h01);
  end
  assign tick = (tick_cnt == 7'(SAMPLE_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  assign rx_timeout = (rx_cnt == TICK_W'(RX_TIMEOUT_TICKS - 1));

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rx_state  <= RX_IDLE;
      rx_prev   <= 1'b1;
      rx_cnt    <= 8'h00;
      rx_strobe <= 8'h00;
      rx_bits   <= 5'h00;
      rx_shift  <= 18'h0_0000;
      rx_done   <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (tick)
        rx_prev <= line_now;
      if (tx_state != TX_OFF)
        rx_state <= RX_IDLE;
      else if (tick)
      begin
        rx_cnt <= 8'(rx_cnt + 8'h01);
        case (rx_state)
          RX_IDLE:
            if (rx_prev && !line_now)
            begin
              rx_state <= RX_START;
              rx_cnt   <= 8'h00;
              rx_bits  <= 5'h00;
            end
          RX_START:
            if (line_now)
            begin
              rx_strobe <= rx_cnt;
              rx_state  <= RX_WAIT;
              rx_cnt    <= 8'h00;
            end
            else if (rx_timeout)
              rx_state <= RX_IDLE;
          RX_WAIT:
            if (rx_prev && !line_now)
            begin
              rx_state <= RX_SAMPLE;
              rx_cnt   <= 8'h00;
            end
            else if (rx_timeout)
              rx_state <= RX_IDLE;
          default:
            // high at strobe is a one
            if (rx_cnt == rx_strobe)
            begin
              rx_shift <= {rx_shift[16:0], line_now};
              rx_bits  <= 5'(rx_bits + 5'h01);
              rx_cnt   <= 8'h00;
              if (rx_bits == 5'(RX_FRAME_BITS - 1))
              begin
                rx_done  <= 1'b1;
                rx_state <= RX_IDLE;
              end
              else
                rx_state <= RX_WAIT;
            end
        endcase
      end
    end
  end

  assign rx_frame = '{command: rx_shift[17:10], data: rx_shift[8:1]};
  assign rx_ok = rx_done && even_ok(rx_shift[17:9]) && even_ok(rx_shift[8:0]);

  ////////////////////////////////////////////////////////////////////////////
  // mode control
  // window accepts only enter command
  assign ack_set = (rx_ok && mode != MODE_NORMAL_OPERATION_STATE &&
                    rx_frame.command == CMD_ENTER_COMMAND_STATE_CMD) ||
                   (rx_ok && mode == MODE_COMMAND_STATE &&
                    rx_frame.command == CMD_CONFIG && rx_frame.data == DATA_START_NOM) ||
                   (CMD_DONE && mode == MODE_COMMAND_STATE);
  assign nvm_set = rx_ok && mode == MODE_COMMAND_STATE && rx_frame.command == CMD_READ_NVM;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      mode    <= MODE_WINDOW;
      win_cnt <= '0;
    end
    else
    begin
      case (mode)
        MODE_WINDOW:
        begin
          win_cnt <= CNT_W'(win_cnt + 1'b1);
          if (rx_ok && rx_frame.command == CMD_ENTER_COMMAND_STATE_CMD)
            mode <= MODE_COMMAND_STATE;
          else if (win_cnt == CNT_W'(WINDOW_CYC - 1))
            mode <= MODE_NORMAL_OPERATION_STATE;
        end
        MODE_COMMAND_STATE:
          if (rx_ok && rx_frame.command == CMD_CONFIG && rx_frame.data == DATA_START_NOM)
            mode <= MODE_NORMAL_OPERATION_STATE;
        default:
          mode <= MODE_NORMAL_OPERATION_STATE;
      endcase
    end
  end
  assign MODE = mode;

  // command high byte, data low byte
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      CMD_VALID <= 1'b0;
      CMD_FRAME <= '0;
    end
    else
    begin
      CMD_VALID <= rx_ok && mode == MODE_COMMAND_STATE && !ack_set && !nvm_set;
      if (rx_ok)
        CMD_FRAME <= rx_frame;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ack_req <= 1'b0;
      nvm_req <= 1'b0;
    end
    else
    begin
      ack_req <= ack_set || (ack_req && !go_ack);
      nvm_req <= nvm_set || (nvm_req && !go_nvm);
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      PULLUP_EN <= 1'b1;
    else
      PULLUP_EN <= (mode == MODE_WINDOW) ||
                   (mode == MODE_NORMAL_OPERATION_STATE && DIGITAL_MODE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // normal-operation sequencer
  assign idle_end  = idle_cyc(UPDATE_RATE);
  assign cycle_end = mode == MODE_NORMAL_OPERATION_STATE && !seq_wait &&
                     idle_cnt == CNT_W'(idle_end - 1'b1);

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      idle_cnt <= '0;
      seq_wait <= 1'b0;
    end
    else if (mode != MODE_NORMAL_OPERATION_STATE)
    begin
      idle_cnt <= '0;
      seq_wait <= 1'b0;
    end
    else if (seq_wait)
    begin
      if (tx_done && tx_src == SRC_NOM)
        seq_wait <= 1'b0;
    end
    else if (cycle_end)
    begin
      idle_cnt <= '0;
      seq_wait <= DIGITAL_MODE;
    end
    else
      idle_cnt <= CNT_W'(idle_cnt + 1'b1);
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      meas_cnt  <= 8'h00;
      TEMP_MEAS <= 1'b0;
    end
    else
    begin
      TEMP_MEAS <= cycle_end && meas_cnt >= temp_last(UPDATE_RATE);
      if (cycle_end)
        meas_cnt <= (meas_cnt >= temp_last(UPDATE_RATE)) ? 8'h00 : 8'(meas_cnt + 8'h01);
    end
  end

  assign remain = CNT_W'(idle_end - idle_cnt);
  always_comb
  begin
    next_phase = PH_ACTIVE;
    if (mode == MODE_NORMAL_OPERATION_STATE && UPDATE_RATE != RATE_1MS && !seq_wait)
    begin
      if (remain <= CNT_W'(CALC_CYC))
        next_phase = PH_CALC;
      else if (remain <= CNT_W'(CALC_CYC + CONVERT_CYC))
        next_phase = PH_CONVERT;
      else if (remain <= CNT_W'(CALC_CYC + CONVERT_CYC + SETTLE_CYC))
        next_phase = PH_SETTLE;
      else if (remain <= CNT_W'(CALC_CYC + CONVERT_CYC + SETTLE_CYC + PWR_ON_CYC))
        next_phase = PH_POWER_ON;
      else
        next_phase = PH_DOWN;
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      PHASE      <= PH_ACTIVE;
      POWER_DOWN <= 1'b0;
    end
    else
    begin
      PHASE      <= next_phase;
      POWER_DOWN <= (next_phase == PH_DOWN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  // line high 32 us before answering
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      quiet_cnt <= '0;
    else if (tx_state == TX_OFF && !line_now)
      quiet_cnt <= '0;
    else if (!quiet)
      quiet_cnt <= CNT_W'(quiet_cnt + 1'b1);
  end
  assign quiet = (quiet_cnt == CNT_W'(STOP_CYC));

  assign go_ack = tx_state == TX_OFF && quiet && ack_req;
  assign go_nvm = tx_state == TX_OFF && quiet && !ack_req && nvm_req;
  assign go_nom = tx_state == TX_OFF && quiet && !ack_req && !nvm_req && seq_wait;

  always_comb
  begin
    tx_byte = ACK_BYTE;
    if (tx_src == SRC_NVM)
      tx_byte = (tx_idx < 4'(NVM_BYTES)) ? NVM_IMAGE[tx_idx] : 8'h00;
    else if (tx_src == SRC_NOM && tx_idx == 4'h0)
      tx_byte = {2'b00, tx_meas.bridge[13:8]};
    else if (tx_src == SRC_NOM && tx_idx == 4'h1)
      tx_byte = tx_meas.bridge[7:0];
    else if (tx_src == SRC_NOM)
      tx_byte = tx_meas.temp;
  end

  // start, eight data msb first, parity
  assign tx_bitv = (tx_bit == 4'(TX_LAST_BIT)) ? ^tx_byte :
                   (tx_bit == 4'h0) ? 1'b0 : tx_byte[3'(4'h8 - tx_bit)];
  assign low_len = (tx_bit == 4'h0) ? (tx_period >> 1) :
                   tx_bitv ? (tx_period >> 2) : CNT_W'(tx_period - (tx_period >> 2));
  assign tx_low  = tx_state == TX_BIT && tx_cnt < low_len;
  assign tx_done = tx_state == TX_STOP && tx_cnt == CNT_W'(STOP_CYC - 1) &&
                   tx_idx == 4'(tx_len - 4'h1);

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      tx_state  <= TX_OFF;
      tx_src    <= SRC_ACK;
      tx_meas   <= '0;
      tx_cnt    <= '0;
      tx_period <= CNT_W'(FAST_BIT_CYC);
      tx_bit    <= 4'h0;
      tx_idx    <= 4'h0;
      tx_len    <= 4'h1;
    end
    else
    begin
      case (tx_state)
        TX_OFF:
          if (go_ack || go_nvm || go_nom)
          begin
            tx_state <= TX_BIT;
            tx_cnt   <= '0;
            tx_bit   <= 4'h0;
            tx_idx   <= 4'h0;
            tx_meas  <= MEAS;
            tx_src   <= go_ack ? SRC_ACK : go_nvm ? SRC_NVM : SRC_NOM;
            tx_len   <= go_ack ? 4'h1 : go_nvm ? 4'(NVM_BYTES) : WITH_TEMP ? 4'h3 : 4'h2;
            tx_period <= UPDATE_RATE[1] ? CNT_W'(SLOW_BIT_CYC) : CNT_W'(FAST_BIT_CYC);
          end
        TX_BIT:
          if (tx_cnt == CNT_W'(tx_period - 1'b1))
          begin
            tx_cnt <= '0;
            if (tx_bit == 4'(TX_LAST_BIT))
              tx_state <= TX_STOP;
            else
              tx_bit <= 4'(tx_bit + 4'h1);
          end
          else
            tx_cnt <= CNT_W'(tx_cnt + 1'b1);
        default:
          // 32 us high after each byte
          if (tx_cnt == CNT_W'(STOP_CYC - 1))
          begin
            tx_cnt <= '0;
            tx_bit <= 4'h0;
            if (tx_done)
              tx_state <= TX_OFF;
            else
            begin
              tx_idx   <= 4'(tx_idx + 4'h1);
              tx_state <= TX_BIT;
            end
          end
          else
            tx_cnt <= CNT_W'(tx_cnt + 1'b1);
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      LINE_OUT <= 1'b1;
      LINE_OE  <= 1'b0;
    end
    else
    begin
      LINE_OUT <= !tx_low;
      LINE_OE  <= tx_state != TX_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_pullup_mode: assert property ((mode == MODE_WINDOW) |=> PULLUP_EN)
    else $error("pull-up off in window");
  a_window_only_cm: assert property ((mode == MODE_WINDOW && rx_ok &&
      rx_frame.command != CMD_ENTER_COMMAND_STATE_CMD) |=> mode != MODE_COMMAND_STATE && !CMD_VALID)
    else $error("window accepted other command");
  a_parity_drop: assert property ((rx_done && !rx_ok) |=> !CMD_VALID && !$rose(ack_req))
    else $error("bad frame answered");
  a_ack_byte: assert property ((tx_state == TX_BIT && tx_src == SRC_ACK)
      |-> tx_byte == ACK_BYTE && tx_len == 4'h1)
    else $error("acknowledge not A5");
  a_start_half: assert property ((tx_state == TX_BIT && tx_bit == 4'h0 &&
      tx_cnt == (tx_period >> 1)) |-> !tx_low ##0 $past(tx_low))
    else $error("start bit not half high");
  a_one_quarter: assert property ((tx_state == TX_BIT && tx_bit != 4'h0 && tx_bitv &&
      tx_cnt == (tx_period >> 2)) |-> !tx_low)
    else $error("one bit low too long");
  a_stop_high: assert property ((tx_state == TX_STOP) |=> LINE_OUT && LINE_OE)
    else $error("line not high in stop");
  a_bridge_pad: assert property ((tx_state == TX_BIT && tx_src == SRC_NOM &&
      tx_idx == 4'h0) |-> tx_byte[7:6] == 2'b00)
    else $error("bridge high byte not padded");
  a_nvm_length: assert property ((tx_state == TX_BIT && tx_src == SRC_NVM)
      |-> tx_len == 4'(NVM_BYTES))
    else $error("memory packet length wrong");
  a_baud_select: assert property ((tx_state != TX_OFF && $stable(UPDATE_RATE))
      |-> tx_period == (UPDATE_RATE[1] ? CNT_W'(SLOW_BIT_CYC) : CNT_W'(FAST_BIT_CYC)))
    else $error("baud not matched to rate");
  a_ack_start: assert property ((go_ack) |=> tx_state == TX_BIT && tx_src == SRC_ACK)
    else $error("acknowledge not started");

  c_ack_sent: cover property (tx_done && tx_src == SRC_ACK);
  c_nvm_dump: cover property (tx_done && tx_src == SRC_NVM);
  c_nom_temp: cover property (tx_done && tx_src == SRC_NOM && tx_len == 4'h3);
  c_rx_timeout: cover property (tick && rx_state == RX_WAIT && rx_timeout);

endmodule

/* design/opl_pkg.sv */
package opl_pkg;

  // clock and sampling
  localparam int CLOCK_HZ         = 40_000_000;
  localparam int CLK_PERIOD_NS    = 25;
  localparam int SAMPLE_HZ        = 512_000;
  localparam int SAMPLE_DIV       = CLOCK_HZ / SAMPLE_HZ;
  localparam int RX_TIMEOUT_US    = 250;
  localparam int RX_TIMEOUT_TICKS = RX_TIMEOUT_US * (SAMPLE_HZ / 1000) / 1000;

  // transmit timing
  localparam int FAST_BAUD_HZ = 32_000;
  localparam int SLOW_BAUD_HZ = 8_000;
  localparam int FAST_BIT_CYC = CLOCK_HZ / FAST_BAUD_HZ;
  localparam int STOP_US      = 32;
  localparam int STOP_CYC     = STOP_US * 1000 / CLK_PERIOD_NS;

  // mode and sequencing times
  localparam int WINDOW_US  = 6000;
  localparam int IDLE_R0_US = 1000;
  localparam int IDLE_R1_US = 4850;
  localparam int IDLE_R2_US = 22_500;
  localparam int IDLE_R3_US = 118_000;
  localparam int PWR_ON_US  = 128;
  localparam int SETTLE_US  = 64;
  localparam int SETTLE_CYC = SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int CONVERT_US = 768;
  localparam int CALC_US    = 160;

  // temperature interval per update-rate code
  localparam int TEMP_EVERY_R0 = 128;
  localparam int TEMP_EVERY_R1 = 64;
  localparam int TEMP_EVERY_R2 = 16;
  localparam int TEMP_EVERY_R3 = 8;

  // update-rate codes
  localparam logic [1:0] RATE_1MS   = 2'b00;
  localparam logic [1:0] RATE_5MS   = 2'b01;
  localparam logic [1:0] RATE_25MS  = 2'b10;
  localparam logic [1:0] RATE_125MS = 2'b11;

  // command bytes and frame shape
  localparam logic [7:0] CMD_READ_NVM   = 8'h00;
  localparam logic [7:0] CMD_CONFIG     = 8'h30;
  localparam logic [7:0] DATA_START_NOM = 8'h00;
  localparam logic [7:0] CMD_ENTER_COMMAND_STATE_CMD   = 8'h50;
  localparam logic [7:0] ACK_BYTE       = 8'hA5;
  localparam int         NVM_BYTES      = 14;
  localparam int         RX_FRAME_BITS  = 18;
  localparam int         TX_LAST_BIT    = 9;
  localparam int         CNT_W          = 23;
  localparam int         TICK_W         = 8;

  typedef logic [CNT_W-1:0] opl_cnt_type;

  typedef enum logic [1:0] {
    MODE_WINDOW                  = 2'b00,
    MODE_COMMAND_STATE           = 2'b01,
    MODE_NORMAL_OPERATION_STATE  = 2'b11
  } opl_mode_type;

  typedef enum logic [1:0] {TX_OFF = 2'b00, TX_BIT = 2'b01, TX_STOP = 2'b11} opl_tx_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_WAIT = 2'b11, RX_SAMPLE = 2'b10
  } opl_rx_type;

  typedef enum logic [1:0] {SRC_ACK = 2'b00, SRC_NVM = 2'b01, SRC_NOM = 2'b11} opl_src_type;

  typedef enum logic [2:0] {
    PH_ACTIVE = 3'b000, PH_DOWN = 3'b001, PH_POWER_ON = 3'b011,
    PH_SETTLE = 3'b010, PH_CONVERT = 3'b110, PH_CALC = 3'b111
  } opl_phase_type;

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] data;
  } opl_cmd_type;

  typedef struct packed {
    logic [13:0] bridge;
    logic [7:0]  temp;
  } opl_meas_type;

endpackage

/* verif/opl_master.sv */
`timescale 1ns/1ps
module opl_master
#(
  parameter int BIT_CYC = 832
)(
  input  wire logic CLOCK,
  input  wire logic LINE,
  input  wire logic DEV_OE,
  output logic      PULL_LOW
);
  logic [8:0] got [$];
  logic [8:0] sh;
  int         nbit = 0;
  int         low = 0;
  int         ref_low = 0;
  initial PULL_LOW = 1'b0;
  ////////////////////////////////////////////////////////////////
  // one frame, 48 kHz
  task automatic send(input logic [7:0] c, input logic [7:0] d, input logic bad);
    logic [18:0] f;
    int          lo;
    f = {1'b0, c, ^c ^ bad, d, ^d};
    for (int i = 18; i >= 0; i--)
    begin
      lo = (i == 18) ? BIT_CYC / 2 : (f[i] ? BIT_CYC / 4 : BIT_CYC - BIT_CYC / 4);
      PULL_LOW = 1'b1;
      repeat (lo) @(negedge CLOCK);
      PULL_LOW = 1'b0;
      repeat (BIT_CYC - lo) @(negedge CLOCK);
    end
    repeat (1280) @(negedge CLOCK);
  endtask
  ////////////////////////////////////////////////////////////////
  // start sets strobe, bits by low length
  always @(posedge CLOCK)
  begin
    if (!LINE)
      low++;
    else if (low != 0)
    begin
      if (DEV_OE && nbit == 0)
        ref_low = low;
      else if (DEV_OE)
        sh = {sh[7:0], low < ref_low};
      if (DEV_OE)
        nbit++;
      if (nbit == 10)
      begin
        got.push_back(sh);
        nbit = 0;
      end
      low = 0;
    end
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import opl_pkg::*;
;
  logic                      clock = 1'b0;
  logic                      rst = 1'b1;
  logic                      cmd_done = 1'b0;
  logic                      pull_low;
  logic                      line_out;
  logic                      line_oe;
  logic                      pullup_en;
  logic                      cmd_valid;
  opl_cmd_type               cmd_frame;
  opl_mode_type              mode;
  logic [NVM_BYTES-1:0][7:0] nvm = '0;
  opl_meas_type              meas = {14'h2abc, 8'h5a};
  wire logic                 line = !(pull_low | (line_oe & !line_out));
  int                        errors = 0;
  int                        compares = 0;
  int                        vcnt = 0;
  logic                      digital_mode = 1'b1;
  logic                      with_temp = 1'b1;
  logic [1:0]                update_rate = RATE_25MS;
  logic                      temp_meas;
  logic                      power_down;
  opl_phase_type             phase;
  int                        tcnt = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) if (cmd_valid === 1'b1) vcnt++;
  always @(posedge clock) if (temp_meas === 1'b1) tcnt++;
  opl_master opl_master_inst (.CLOCK(clock), .LINE(line), .DEV_OE(line_oe), .PULL_LOW(pull_low));
  opl_link #(.SLOW_BIT_CYC(400), .WINDOW_CYC(40000), .IDLE_R0_CYC(3000), .IDLE_R1_CYC(1000),
    .IDLE_R2_CYC(3000), .IDLE_R3_CYC(1000), .PWR_ON_CYC(50), .CONVERT_CYC(200),
    .CALC_CYC(100)) opl_link_inst (.CLOCK(clock), .RST(rst), .LINE_IN(line),
    .LINE_OUT(line_out), .LINE_OE(line_oe), .PULLUP_EN(pullup_en),
    .DIGITAL_MODE(digital_mode), .WITH_TEMP(with_temp), .UPDATE_RATE(update_rate),
    .MEAS(meas), .NVM_IMAGE(nvm), .CMD_VALID(cmd_valid), .CMD_FRAME(cmd_frame),
    .CMD_DONE(cmd_done), .MODE(mode), .TEMP_MEAS(temp_meas), .POWER_DOWN(power_down),
    .PHASE(phase));
  ////////////////////////////////////////////////////////////////
  function automatic logic [8:0] pb(input logic [7:0] b);
    return {b, ^b};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_bytes(input int n);
    int k;
    k = 0;
    while ((opl_master_inst.got.size() < n || line_oe !== 1'b0) && k < 60000)
    begin
      @(negedge clock);
      k++;
    end
    if (k >= 60000)
    begin
      errors++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({pullup_en, line_oe, line_out, mode}, {3'b101, MODE_WINDOW});
  endtask
  task automatic t_parity();
    opl_master_inst.send(CMD_ENTER_COMMAND_STATE_CMD, 8'h00, 1'b1);
    repeat (300) @(negedge clock);
    chk(opl_master_inst.got.size(), 0);
    chk(mode, MODE_WINDOW);
  endtask
  task automatic t_enter();
    opl_master_inst.send(CMD_ENTER_COMMAND_STATE_CMD, 8'h3c, 1'b0);
    wait_bytes(1);
    chk(opl_master_inst.got[0], pb(ACK_BYTE));
    chk(mode, MODE_COMMAND_STATE);
  endtask
  task automatic t_cmd();
    vcnt = 0;
    opl_master_inst.send(8'h80, 8'h12, 1'b0);
    chk(vcnt, 1);
    chk(cmd_frame, 16'h8012);
    chk(opl_master_inst.got.size(), 1);
    cmd_done = 1'b1;
    @(negedge clock);
    cmd_done = 1'b0;
    wait_bytes(2);
    chk(opl_master_inst.got[1], pb(ACK_BYTE));
  endtask
  task automatic t_nom();
    opl_master_inst.send(CMD_CONFIG, DATA_START_NOM, 1'b0);
    wait_bytes(6);
    chk(opl_master_inst.got[2], pb(ACK_BYTE));
    chk(opl_master_inst.got[3], pb({2'b00, meas.bridge[13:8]}));
    chk(opl_master_inst.got[4], pb(meas.bridge[7:0]));
    chk(opl_master_inst.got[5], pb(meas.temp));
    chk({pullup_en, mode}, {1'b1, MODE_NORMAL_OPERATION_STATE});
    repeat (40) @(negedge clock);
    chk({power_down, phase}, {1'b1, PH_DOWN});
    repeat (160) @(negedge clock);
    chk({power_down, phase}, {1'b0, PH_SETTLE});
    chk(tcnt, 0);
    digital_mode = 1'b0;
    repeat (2) @(negedge clock);
    chk(pullup_en, 1'b0);
  endtask
  task automatic t_rerun();
    rst = 1'b1;
    repeat (2) @(negedge clock);
    chk({pullup_en, line_oe, line_out, cmd_valid, power_down, phase, mode},
        {5'b10100, PH_ACTIVE, MODE_WINDOW});
    rst = 1'b0;
    repeat (3) @(negedge clock);
    chk({pullup_en, line_oe, mode}, {2'b10, MODE_WINDOW});
  endtask
  initial
  begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    t_reset();
    t_parity();
    t_enter();
    t_cmd();
    t_nom();
    t_rerun();
    close_out();
  end
endmodule
